// file: design/pif_irq.sv
// pwm interrupt enable and flag logic for two groups of four channels
//
// Notes on behaviour
// - pair 0/1 type bit 16 picks period event
// - pair 2/3 type bit 17 picks period event
// - type bits only matter in center-aligned mode
// - duty interrupt enables at bits 11..8
// - period interrupt enables at bits 3..0
// - duty flag sets on down-count comparator match
// - write one clears duty flag, zero keeps
// - edge mode, comparator equals period: no duty
// - period flag sets on selected counter condition
// - write one clears only those period flags
// - two identical groups, pairs 0/1,2/3 and 4/5,6/7
`timescale 1ns/1ps

module pif_irq
  import pif_pkg::*;
#(
  parameter int N_GROUPS = PIF_N_GROUPS,
  parameter int N_CH     = PIF_N_CH
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  // ahb-lite slave
  input  wire logic                      i_hsel,
  input  wire logic [PIF_ADDR_W-1:0]     i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [PIF_DATA_W-1:0]     i_hwdata,
  input  wire logic                      i_hready,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  output logic      [PIF_DATA_W-1:0]     o_hrdata,
  // counter view, channel g*4+c
  input  pif_chan_s [N_GROUPS*N_CH-1:0]  i_chan,
  // interrupts
  output logic      [N_GROUPS-1:0]       o_irq_grp,
  output logic                           o_irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (N_GROUPS != PIF_N_GROUPS || N_CH != PIF_N_CH) begin : g_chk
    $error("pif_irq: only two groups of four channels are supported");
  end

  // ----------------------------------------------------------------
  // channel event detection
  // ----------------------------------------------------------------
  logic [N_GROUPS-1:0][N_CH-1:0] duty_ev;
  logic [N_GROUPS-1:0][N_CH-1:0] period_ev;
  pif_state_s                    st_q;
  pif_state_s                    st_d;

  for (genvar g = 0; g < N_GROUPS; g++) begin : g_grp
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
      pif_chan_s ch;
      logic      type_sel;
      logic      at_zero;
      logic      at_period;
      logic      at_cmp;
      logic      cmp_eq_prd;

      assign ch         = i_chan[g*N_CH+c];
      assign at_zero    = (ch.count == '0);
      assign at_period  = (ch.count == ch.period_value);
      assign at_cmp     = (ch.count == ch.comparator_value);
      assign cmp_eq_prd = (ch.comparator_value == ch.period_value);

      // pair 0/1 uses the low type bit, pair 2/3 the high one
      if (c < PIF_PAIR_SPLIT) begin : g_lo
        assign type_sel = st_q.irq_enable_reg[g][PIF_TYPE_LO_BIT];
      end else begin : g_hi
        assign type_sel = st_q.irq_enable_reg[g][PIF_TYPE_HI_BIT];
      end

      // duty event: down count reaching the comparator
      assign duty_ev[g][c] = ch.step && ch.down && at_cmp &&
                             !(!ch.center && cmp_eq_prd);

      // period event: underflow, or period match when selected
      assign period_ev[g][c] = ch.step &&
                               ((ch.center && type_sel) ? at_period
                                                        : (ch.down && at_zero));
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite address phase decode
  // ----------------------------------------------------------------
  logic       ap_valid;
  logic       ap_grp;
  logic       ap_in_map;
  logic       ap_enable;
  logic       ap_flags;
  logic [7:0] ap_off;

  assign ap_valid  = i_hsel && i_hready && (i_htrans[1] != 1'b0);
  assign ap_grp    = i_haddr[PIF_GRP_SEL_BIT];
  assign ap_off    = i_haddr[7:0];
  assign ap_in_map = ((i_haddr & ~PIF_GRP_B_BASE) == PIF_GRP_A_BASE) ||
                     ((i_haddr & ~PIF_GRP_B_BASE) == (i_haddr & '0));
  assign ap_enable = ap_valid && (ap_off == PIF_OFF_ENABLE) &&
                     (i_haddr[PIF_ADDR_W-1:PIF_GRP_SEL_BIT+1] == '0);
  assign ap_flags  = ap_valid && (ap_off == PIF_OFF_FLAGS) &&
                     (i_haddr[PIF_ADDR_W-1:PIF_GRP_SEL_BIT+1] == '0);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] rd_v;
    set_v = '0;
    clr_v = '0;
    rd_v  = '0;
    st_d  = st_q;

    // data phase of a previous write
    if (st_q.dp_write && st_q.dp_enable) begin
      st_d.irq_enable_reg[st_q.dp_grp] = i_hwdata & PIF_ENABLE_MASK;
    end

    for (int g = 0; g < N_GROUPS; g++) begin
      set_v = '0;
      clr_v = '0;
      for (int c = 0; c < N_CH; c++) begin
        set_v[PIF_DUTY_LSB+c]   = duty_ev[g][c];
        set_v[PIF_PERIOD_LSB+c] = period_ev[g][c];
      end
      if (st_q.dp_write && st_q.dp_flags && (st_q.dp_grp == g[0])) begin
        clr_v = i_hwdata & PIF_FLAGS_MASK;
      end
      // a new event wins over a clear in the same cycle
      st_d.irq_flag_reg[g] = ((st_q.irq_flag_reg[g] & ~clr_v) | set_v)
                             & PIF_FLAGS_MASK;
    end

    // capture the address phase
    st_d.dp_write  = ap_valid && i_hwrite;
    st_d.dp_grp    = ap_grp;
    st_d.dp_enable = ap_enable;
    st_d.dp_flags  = ap_flags;

    // read data is fetched in the address phase
    if (ap_valid && !i_hwrite) begin
      if (ap_enable) begin
        rd_v = st_d.irq_enable_reg[ap_grp];
      end else if (ap_flags) begin
        rd_v = st_q.irq_flag_reg[ap_grp];
      end else begin
        rd_v = '0;
      end
      st_d.rdata = rd_v;
    end else if (ap_valid && !ap_in_map) begin
      st_d.rdata = '0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q.irq_enable_reg <= {N_GROUPS{PIF_ENABLE_RST}};
      st_q.irq_flag_reg   <= {N_GROUPS{PIF_FLAGS_RST}};
      st_q.dp_write       <= 1'b0;
      st_q.dp_grp         <= 1'b0;
      st_q.dp_enable      <= 1'b0;
      st_q.dp_flags       <= 1'b0;
      st_q.rdata          <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_hreadyout = 1'b1;
  assign o_hresp     = PIF_HRESP_OKAY;
  assign o_hrdata    = st_q.rdata;

  for (genvar g = 0; g < N_GROUPS; g++) begin : g_irq
    assign o_irq_grp[g] = |(st_q.irq_flag_reg[g] & st_q.irq_enable_reg[g]
                            & PIF_FLAGS_MASK);
  end

  assign o_irq = |o_irq_grp;

endmodule

// file: design/pif_pkg.sv
// package: constants and carriers of the pwm interrupt flag block
package pif_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PIF_N_GROUPS = 2;
  localparam int PIF_N_CH     = 4;
  localparam int PIF_CNT_W    = 16;
  localparam int PIF_ADDR_W   = 12;
  localparam int PIF_DATA_W   = 32;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int                  PIF_GRP_SEL_BIT = 8;
  localparam logic [7:0]          PIF_OFF_ENABLE  = 8'h40;
  localparam logic [7:0]          PIF_OFF_FLAGS   = 8'h44;
  localparam logic [PIF_ADDR_W-1:0] PIF_GRP_A_BASE = 12'h000;
  localparam logic [PIF_ADDR_W-1:0] PIF_GRP_B_BASE = 12'h100;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int PIF_PERIOD_LSB  = 0;
  localparam int PIF_DUTY_LSB    = 8;
  localparam int PIF_TYPE_LO_BIT = 16;
  localparam int PIF_TYPE_HI_BIT = 17;
  localparam int PIF_PAIR_SPLIT  = 2;

  localparam logic [31:0] PIF_ENABLE_MASK = 32'h0003_0F0F;
  localparam logic [31:0] PIF_FLAGS_MASK  = 32'h0000_0F0F;
  localparam logic [31:0] PIF_ENABLE_RST  = 32'h0000_0000;
  localparam logic [31:0] PIF_FLAGS_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic       PIF_HRESP_OKAY = 1'b0;
  localparam logic [1:0] PIF_HTRANS_IDLE = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // one channel's counter view, supplied by the counter logic
  typedef struct packed {
    logic [PIF_CNT_W-1:0] count;
    logic [PIF_CNT_W-1:0] comparator_value;
    logic [PIF_CNT_W-1:0] period_value;
    logic                 step;
    logic                 down;
    logic                 center;
  } pif_chan_s;

  typedef struct packed {
    logic [PIF_N_GROUPS-1:0][31:0] irq_enable_reg;
    logic [PIF_N_GROUPS-1:0][31:0] irq_flag_reg;
    logic                          dp_write;
    logic                          dp_grp;
    logic                          dp_enable;
    logic                          dp_flags;
    logic [31:0]                   rdata;
  } pif_state_s;

endpackage

// file: tb/pif_irq_checker.sv
// assertion checker bound to the pwm interrupt flag block
`timescale 1ns/1ps
module pif_irq_checker
  import pif_pkg::*;
#(
  parameter int N_GROUPS = PIF_N_GROUPS,
  parameter int N_CH     = PIF_N_CH
) (
  input wire logic                 i_clk, i_rst_n, i_hsel, i_hwrite,
  input wire logic                 i_hready, o_hreadyout, o_hresp, o_irq,
  input wire logic [PIF_ADDR_W-1:0] i_haddr,
  input wire logic [1:0]           i_htrans,
  input wire logic [2:0]           i_hsize,
  input wire logic [31:0]          i_hwdata, o_hrdata,
  input wire pif_chan_s [N_GROUPS*N_CH-1:0] i_chan,
  input wire logic [N_GROUPS-1:0]  o_irq_grp
);
  // ----------------------------------------
  // data phase tracking and step summary
  // ----------------------------------------
  logic [9:0] ph_q;  // write, read, address low byte
  logic       stp;
  wire        tk = i_hsel & i_hready & i_htrans[1];
  always_comb begin
    stp = 1'b0;
    for (int i = 0; i < N_GROUPS*N_CH; i++) stp |= i_chan[i].step;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ph_q <= 10'h000;
    else ph_q <= {tk & i_hwrite, tk & ~i_hwrite, i_haddr[7:0]};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_irq_is_or: assert property (o_irq == |o_irq_grp)
    else $error("irq is not the or of group irqs");
  chk_irq_rise: assert property (
    $rose(o_irq) |-> $past(stp) || $past(ph_q[9]))
    else $error("irq rose with no event or write");
  chk_irq_fall: assert property ($fell(o_irq) |-> $past(ph_q[9]))
    else $error("irq fell with no write");
  chk_grp_stable: assert property (
    !stp && !ph_q[9] |=> $stable(o_irq_grp))
    else $error("group irq changed with no cause");
  chk_flag_rsv: assert property (
    ph_q[8] && ph_q[7:0] == PIF_OFF_FLAGS |-> !(o_hrdata & ~PIF_FLAGS_MASK))
    else $error("flag read shows reserved bits");
  chk_en_rsv: assert property (
    ph_q[8] && ph_q[7:0] == PIF_OFF_ENABLE |-> !(o_hrdata & ~PIF_ENABLE_MASK))
    else $error("enable read shows reserved bits");
  chk_unmapped_rd: assert property (
    ph_q[8] && ph_q[7:0] != 8'h40 && ph_q[7:0] != 8'h44 |-> o_hrdata == 0)
    else $error("unmapped read not zero");
  chk_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready and okay");
  cover property ($rose(o_irq));
  cover property ($fell(o_irq));
  cover property (ph_q[8] && ph_q[7:0] == PIF_OFF_FLAGS && o_hrdata != 0);
endmodule
bind pif_irq pif_irq_checker #(.N_GROUPS(N_GROUPS), .N_CH(N_CH)) i_chk (.*);

// file: tb/tb_top.sv
// self-checking bench of the pwm interrupt flag block
`timescale 1ns/1ps
module tb_top import pif_pkg::*;;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic [11:0] i_haddr = 12'h000;
  logic [1:0]  i_htrans = 2'h0, o_irq_grp;
  logic [31:0] i_hwdata = 32'h0, o_hrdata, rv, en [2], fl [2];
  logic        o_hreadyout, o_hresp, o_irq;
  pif_chan_s [7:0] i_chan = '0;
  int          n_mismatch = 0, check_count = 0;
  pif_irq i_pif_irq (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout),
    .o_hreadyout, .o_hresp, .o_hrdata, .i_chan, .o_irq_grp, .o_irq);
  initial forever #2.5 i_clk = ~i_clk;
  // ----------------------------------------
  // bus, event and compare tasks
  // ----------------------------------------
  task automatic chk(logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic irq_chk();
    logic [1:0] g = {|(fl[1] & en[1]), |(fl[0] & en[0])};
    chk({o_irq, o_irq_grp}, {|g, g});
  endtask
  task automatic bus(int g, logic [7:0] off, logic w, logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= {3'h0, g[0], off};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= PIF_HTRANS_IDLE;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rv = o_hrdata;
  endtask
  task automatic wr(int g, logic [7:0] off, logic [31:0] d);
    bus(g, off, 1'b1, d);
    if (off == PIF_OFF_ENABLE) en[g] = d & PIF_ENABLE_MASK;
    if (off == PIF_OFF_FLAGS) fl[g] &= ~d;
  endtask
  task automatic rd(int g, logic [7:0] off, logic [31:0] e);
    bus(g, off, 1'b0, 32'h0);
    chk(rv, e);
    @(negedge i_clk);
    irq_chk();
  endtask
  function automatic logic [31:0] hit(int k, logic [31:0] e, pif_chan_s c);
    logic [31:0] r = 32'h0;
    if (c.down && c.count == c.comparator_value &&
        (c.center || c.comparator_value != c.period_value)) r[8+k] = 1'b1;
    if (c.center && e[16+k/2] ? c.count == c.period_value
        : c.down && c.count == 16'h0000) r[k] = 1'b1;
    return r;
  endfunction
  task automatic ev(int ch, pif_chan_s c);
    c.step = 1'b1;
    @(posedge i_clk);
    i_chan[ch] <= c;
    fl[ch/4] |= hit(ch%4, en[ch/4], c);
    @(posedge i_clk);
    i_chan[ch].step <= 1'b0;
    @(negedge i_clk);
    irq_chk();
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    int        ch;
    pif_chan_s c;
    void'($urandom(32'h69ED));
    en = '{32'h0, 32'h0};
    fl = '{32'h0, 32'h0};
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      rd(g, PIF_OFF_ENABLE, PIF_ENABLE_RST);
      rd(g, PIF_OFF_FLAGS, PIF_FLAGS_RST);
      wr(g, 8'h48, 32'hFFFFFFFF);
      rd(g, 8'h48, 32'h0);
      wr(g, PIF_OFF_ENABLE, 32'hFFFFFFFF);
      rd(g, PIF_OFF_ENABLE, en[g]);
    end
    wr(0, PIF_OFF_ENABLE, 32'h0);
    ev(1, {16'h0007, 16'h0007, 16'h0007, 3'h2});
    ev(6, {16'h0009, 16'h0003, 16'h0009, 3'h1});
    ev(0, {16'h0000, 16'h0005, 16'h0009, 3'h2});
    rd(0, PIF_OFF_FLAGS, fl[0]);
    rd(1, PIF_OFF_FLAGS, fl[1]);
    repeat (400) begin
      ch = $urandom_range(7);
      c = {16'($urandom_range(3)), 16'($urandom_range(3)),
           16'($urandom_range(3)), 1'b0, 2'($urandom)};
      case ($urandom_range(4))
        0: wr(ch/4, PIF_OFF_ENABLE, $urandom());
        1: wr(ch/4, PIF_OFF_FLAGS, $urandom());
        default: ev(ch, c);
      endcase
      if (ch[0]) rd(ch/4, PIF_OFF_FLAGS, fl[ch/4]);
      if (ch[1]) rd(ch/4, PIF_OFF_ENABLE, en[ch/4]);
    end
    give_verdict();
  end
endmodule
